// *** rtl/cior_pkg.sv ***
/*
 * Constants for the camera I/O line routing block: register offsets,
 * field positions, reset values and the source/trigger encodings.
 * Assumes a 32-bit classic Wishbone slave with word-aligned registers.
 */
package cior_pkg;

    // ==========================================================
    // Register map (byte addresses)
    localparam logic [7:0] CIOR_LINE_SEL_ADDR   = 8'h00;
    localparam logic [7:0] CIOR_LINE_CFG_ADDR   = 8'h04;
    localparam logic [7:0] CIOR_LINE_STAT_ADDR  = 8'h08;
    localparam logic [7:0] CIOR_USER_OUT_ADDR   = 8'h0c;
    localparam logic [7:0] CIOR_TRIG_SEL_ADDR   = 8'h10;
    localparam logic [7:0] CIOR_TRIG_SRC_ADDR   = 8'h14;

    // ==========================================================
    // Field positions in the line configuration register
    localparam int CIOR_CFG_SRC_LSB    = 0;
    localparam int CIOR_CFG_INV_BIT    = 4;
    localparam int CIOR_CFG_MODE_BIT   = 8;
    localparam int CIOR_CFG_FMT_LSB    = 12;

    // ==========================================================
    // Sizes
    localparam int CIOR_NUM_LINES      = 8;
    localparam int CIOR_NUM_TRIG       = 8;

    // ==========================================================
    // Line formats
    localparam logic [1:0] CIOR_FMT_NONE = 2'h0;
    localparam logic [1:0] CIOR_FMT_TTL  = 2'h1;
    localparam logic [1:0] CIOR_FMT_LVDS = 2'h2;
    localparam logic [1:0] CIOR_FMT_OPTO = 2'h3;

    // Per-line direction (1 = output) and format, line 1 at bit 0
    localparam logic [7:0]  CIOR_LINE_IS_OUT = 8'h0f;
    localparam logic [15:0] CIOR_LINE_FMT    = 16'h9ff5;

    // ==========================================================
    // Drive source encodings
    localparam logic [3:0] CIOR_SRC_OFF        = 4'h0;
    localparam logic [3:0] CIOR_SRC_ACQ_TWAIT  = 4'h1;
    localparam logic [3:0] CIOR_SRC_ACQ_ACT    = 4'h2;
    localparam logic [3:0] CIOR_SRC_FRM_TWAIT  = 4'h3;
    localparam logic [3:0] CIOR_SRC_FRM_ACT    = 4'h4;
    localparam logic [3:0] CIOR_SRC_EXP_ACT    = 4'h5;
    localparam logic [3:0] CIOR_SRC_XFER_WAIT  = 4'h6;
    localparam logic [3:0] CIOR_SRC_CNT_ACT    = 4'h7;
    localparam logic [3:0] CIOR_SRC_TMR_ACT    = 4'h8;
    localparam logic [3:0] CIOR_SRC_USER0      = 4'h9;
    localparam logic [3:0] CIOR_SRC_USER3      = 4'hc;

    // ==========================================================
    // Trigger source encodings
    localparam logic [3:0] CIOR_TRG_SOFTWARE   = 4'h0;
    localparam logic [3:0] CIOR_TRG_LINE5      = 4'h1;
    localparam logic [3:0] CIOR_TRG_LINE8      = 4'h4;
    localparam logic [3:0] CIOR_TRG_TMR_START  = 4'h5;
    localparam logic [3:0] CIOR_TRG_TMR_END    = 4'h6;
    localparam logic [3:0] CIOR_TRG_TMR_ACT    = 4'h7;
    localparam logic [3:0] CIOR_TRG_CNT_START  = 4'h8;
    localparam logic [3:0] CIOR_TRG_CNT_END    = 4'h9;
    localparam logic [3:0] CIOR_TRG_USER0      = 4'ha;
    localparam logic [3:0] CIOR_TRG_USER3      = 4'hd;
    localparam logic [3:0] CIOR_TRG_ACTION1    = 4'he;
    localparam logic [3:0] CIOR_TRG_ACTION2    = 4'hf;

    // ==========================================================
    // Reset values
    localparam logic [3:0] CIOR_SRC_RST  = 4'h0;
    localparam logic [3:0] CIOR_TRG_RST  = 4'h0;

endpackage

// *** rtl/cior_top.sv ***
/*
 * Camera I/O line routing: per-line drive source and invert, per
 * trigger function source selection, Wishbone classic register slave.
 * Assumes status and event inputs are synchronous to clk_i; line pins
 * come from outside and are synchronised here.
 */
`timescale 1ns/1ps
`default_nettype none
module cior_top
    import cior_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Internal status sources, same clock
    input  wire logic        acq_trig_wait_i,
    input  wire logic        acq_active_i,
    input  wire logic        frame_trig_wait_i,
    input  wire logic        frame_active_i,
    input  wire logic        exposure_active_i,
    input  wire logic        transfer_wait_i,
    input  wire logic        counter_active_i,
    input  wire logic        timer_active_i,
    // Trigger events, same clock
    input  wire logic        sw_trig_i,
    input  wire logic        timer_start_i,
    input  wire logic        timer_end_i,
    input  wire logic        counter_start_i,
    input  wire logic        counter_end_i,
    input  wire logic [1:0]  action_i,
    // Terminals: lines 1..4 out, lines 5..8 in
    input  wire logic [3:0]  line_in_i,
    output logic      [3:0]  line_out_o,
    // Fired trigger, one bit per trigger function
    output logic      [7:0]  trig_o
);

    // ==========================================================
    // State
    logic [2:0]  line_sel,   next_line_sel;
    logic [2:0]  trig_sel,   next_trig_sel;
    logic [3:0]  user_out,   next_user_out;
    logic [31:0] src_vec,    next_src_vec;
    logic [7:0]  inv,        next_inv;
    logic [31:0] trg_vec,    next_trg_vec;
    logic [3:0]  in_s1, in_s2;
    logic [7:0]  lvl,        next_lvl;
    logic [3:0]  next_out;
    logic [7:0]  next_trig;
    logic [31:0] next_dat;
    logic        next_ack;
    logic        wr;

    logic [3:0]  wsrc;
    logic        sel_out;
    // A net, so each generate branch can drive its own bit
    wire  [7:0]  raw;

    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
    assign wsrc = wb_dat_i[CIOR_CFG_SRC_LSB +: 4];
    assign sel_out = CIOR_LINE_IS_OUT[line_sel];

    // ==========================================================
    // Input line synchroniser
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            in_s1 <= 4'h0;
            in_s2 <= 4'h0;
        end
        else if (ce_i)
        begin
            in_s1 <= line_in_i;
            in_s2 <= in_s1;
        end
    end

    // ==========================================================
    // Per-line level: output lines from selected source, inputs from pins
    // fixed line directions
    genvar g;
    generate
        for (g = 0; g < CIOR_NUM_LINES; g++)
        begin : g_line
            logic [3:0] s;
            assign s = src_vec[4*g +: 4];
            if (g < 4)
            begin : g_out
                logic r;
                always_comb
                begin
                    case (s)
                        CIOR_SRC_ACQ_TWAIT: r = acq_trig_wait_i;
                        CIOR_SRC_ACQ_ACT:   r = acq_active_i;
                        CIOR_SRC_FRM_TWAIT: r = frame_trig_wait_i;
                        CIOR_SRC_FRM_ACT:   r = frame_active_i;
                        CIOR_SRC_EXP_ACT:   r = exposure_active_i;
                        CIOR_SRC_XFER_WAIT: r = transfer_wait_i;
                        CIOR_SRC_CNT_ACT:   r = counter_active_i;
                        CIOR_SRC_TMR_ACT:   r = timer_active_i;
                        default:
                        begin
                            if (s >= CIOR_SRC_USER0 && s <= CIOR_SRC_USER3)
                                r = user_out[2'(s - CIOR_SRC_USER0)];
                            else
                                r = 1'b0;
                        end
                    endcase
                end
                assign raw[g] = r;
            end
            else
            begin : g_in
                assign raw[g] = in_s2[g-4];
            end
        end
    endgenerate

    // invert, status shows result; Off gives a low raw level, so an inverted Off line is high
    always_comb
    begin
        next_lvl = raw ^ inv;
        next_out = lvl[3:0];
    end

    // ==========================================================
    // Trigger routing per trigger function
    // trigger source select
    always_comb
    begin
        logic [3:0] t;
        t = 4'h0;
        for (int k = 0; k < CIOR_NUM_TRIG; k++)
        begin
            t = trg_vec[4*k +: 4];
            if (t == CIOR_TRG_SOFTWARE)
                next_trig[k] = sw_trig_i && (trig_sel == 3'(k));
            else if (t <= CIOR_TRG_LINE8)
                next_trig[k] = lvl[2'(t - CIOR_TRG_LINE5) + 3'd4];
            else if (t == CIOR_TRG_TMR_START)
                next_trig[k] = timer_start_i;
            else if (t == CIOR_TRG_TMR_END)
                next_trig[k] = timer_end_i;
            else if (t == CIOR_TRG_TMR_ACT)
                next_trig[k] = timer_active_i;
            else if (t == CIOR_TRG_CNT_START)
                next_trig[k] = counter_start_i;
            else if (t == CIOR_TRG_CNT_END)
                next_trig[k] = counter_end_i;
            else if (t <= CIOR_TRG_USER3)
                next_trig[k] = user_out[2'(t - CIOR_TRG_USER0)];
            else
                next_trig[k] = action_i[t == CIOR_TRG_ACTION2];
        end
    end

    // ==========================================================
    // Register writes and reads
    always_comb
    begin
        next_line_sel = line_sel;
        next_trig_sel = trig_sel;
        next_user_out = user_out;
        next_src_vec  = src_vec;
        next_inv      = inv;
        next_trg_vec  = trg_vec;
        next_ack      = wb_cyc_i && wb_stb_i && !wb_ack_o;
        next_dat      = 32'h0;
        if (wr)
        begin
            if (wb_adr_i == CIOR_LINE_SEL_ADDR)
                next_line_sel = wb_dat_i[2:0];
            else if (wb_adr_i == CIOR_LINE_CFG_ADDR)
            begin
                // frame active refused on an input line
                if (!(wsrc == CIOR_SRC_FRM_ACT && !sel_out) && wsrc <= CIOR_SRC_USER3)
                    next_src_vec[4*line_sel +: 4] = wsrc;
                next_inv[line_sel] = wb_dat_i[CIOR_CFG_INV_BIT];
            end
            else if (wb_adr_i == CIOR_USER_OUT_ADDR)
                next_user_out = wb_dat_i[3:0];
            else if (wb_adr_i == CIOR_TRIG_SEL_ADDR)
                next_trig_sel = wb_dat_i[2:0];
            else if (wb_adr_i == CIOR_TRIG_SRC_ADDR)
                next_trg_vec[4*trig_sel +: 4] = wb_dat_i[3:0];
        end
        if (wb_adr_i == CIOR_LINE_SEL_ADDR)
            next_dat = {29'h0, line_sel};
        else if (wb_adr_i == CIOR_LINE_CFG_ADDR)
        begin
            next_dat[CIOR_CFG_SRC_LSB +: 4] = src_vec[4*line_sel +: 4];
            next_dat[CIOR_CFG_INV_BIT]      = inv[line_sel];
            next_dat[CIOR_CFG_MODE_BIT]     = sel_out;
            next_dat[CIOR_CFG_FMT_LSB +: 2] = CIOR_LINE_FMT[2*line_sel +: 2];
        end
        else if (wb_adr_i == CIOR_LINE_STAT_ADDR)
            next_dat = {24'h0, lvl};
        else if (wb_adr_i == CIOR_USER_OUT_ADDR)
            next_dat = {28'h0, user_out};
        else if (wb_adr_i == CIOR_TRIG_SEL_ADDR)
            next_dat = {29'h0, trig_sel};
        else if (wb_adr_i == CIOR_TRIG_SRC_ADDR)
            next_dat = {28'h0, trg_vec[4*trig_sel +: 4]};
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            line_sel   <= 3'h0;
            trig_sel   <= 3'h0;
            user_out   <= 4'h0;
            src_vec    <= {CIOR_NUM_LINES{CIOR_SRC_RST}};
            inv        <= 8'h0;
            trg_vec    <= {CIOR_NUM_TRIG{CIOR_TRG_RST}};
            lvl        <= 8'h0;
            line_out_o <= 4'h0;
            trig_o     <= 8'h0;
            wb_ack_o   <= 1'b0;
            wb_dat_o   <= 32'h0;
        end
        else if (ce_i)
        begin
            line_sel   <= next_line_sel;
            trig_sel   <= next_trig_sel;
            user_out   <= next_user_out;
            src_vec    <= next_src_vec;
            inv        <= next_inv;
            trg_vec    <= next_trg_vec;
            lvl        <= next_lvl;
            line_out_o <= next_out;
            trig_o     <= next_trig;
            wb_ack_o   <= next_ack;
            wb_dat_o   <= next_dat;
        end
    end

endmodule
`default_nettype wire

// *** tb/cior_assertions.sv ***
/* Port checker for the line routing block.
   Assumes no bus request is open while ce_i is low. */
`timescale 1ns/1ps
`default_nettype none
module cior_assertions
    import cior_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        ce_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic [3:0]  line_out_o,
    input wire logic [7:0]  trig_o
);
    // ==========================================
    // Shadow of the line selector
    logic       rq;
    logic [2:0] sel;
    logic [2:0] next_sel;
    logic [1:0] fmt;
    assign rq = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
    assign fmt = (sel < 3'h2 || sel == 3'h6) ? 2'h1 : (sel == 3'h7) ? 2'h2 : 2'h3;
    always_comb
        next_sel = (rq && wb_we_i && wb_sel_i[0] && wb_adr_i == CIOR_LINE_SEL_ADDR)
            ? wb_dat_i[2:0] : sel;
    always_ff @(posedge clk_i)
        sel <= rst_i ? 3'h0 : next_sel;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ==========================================
    // Assertions
    a_ack_answer: assert property (rq |=> wb_ack_o)
        else $error("request not acknowledged");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property (wb_ack_o |-> $past(rq))
        else $error("ack without request");
    a_unmapped_zero: assert property (rq && !wb_we_i && wb_adr_i >= 8'h18 |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_mode_fixed: assert property (rq && !wb_we_i && wb_adr_i == CIOR_LINE_CFG_ADDR
        |=> wb_dat_o[8] == (sel < 3'h4))
        else $error("line direction wrong");
    a_format_auto: assert property (rq && !wb_we_i && wb_adr_i == CIOR_LINE_CFG_ADDR
        |=> wb_dat_o[13:12] == fmt)
        else $error("line format wrong");
    a_stat_width: assert property (rq && !wb_we_i && wb_adr_i == CIOR_LINE_STAT_ADDR
        |=> wb_dat_o[31:8] == 24'h0)
        else $error("status upper bits set");
    a_trig_width: assert property (rq && !wb_we_i && wb_adr_i == CIOR_TRIG_SRC_ADDR
        |=> wb_dat_o[31:4] == 28'h0)
        else $error("trigger source upper bits set");
    a_reset_clear: assert property ($fell(rst_i) |-> line_out_o == 4'h0 && trig_o == 8'h0)
        else $error("outputs active after reset");
    a_ce_freeze: assert property (!ce_i |=> $stable(line_out_o) && $stable(trig_o)
        && $stable(wb_dat_o))
        else $error("state moved with enable low");
endmodule
bind cior_top cior_assertions i_chk (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .line_out_o, .trig_o);
`default_nettype wire

// *** tb/cior_equip.sv ***
/* External equipment on the line terminals.
   Assumes the bench commands the input pin levels. */
`timescale 1ns/1ps
`default_nettype none
module cior_equip
(
    // Commands
    input  wire logic [3:0] level_i,
    // Terminals
    input  wire logic [3:0] line_out_i,
    output logic      [3:0] line_in_o,
    output logic      [3:0] seen_o
);
    // lines five to eight inputs
    // Skewed off the clock so the synchronisers see true async edges
    initial line_in_o = 4'h0;
    always @(level_i)
        line_in_o <= #17 level_i;
    assign seen_o = line_out_i;
endmodule
`default_nettype wire

// *** tb/cior_bench.sv ***
/* Self-checking bench for the line routing block.
   Assumes the block acks one request at a time. */
`timescale 1ns/1ps
`default_nettype none
module cior_bench;
    logic        clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, i;
    logic [7:0]  wb_adr_i, st, trig_o;
    logic [3:0]  wb_sel_i, line_in_i, line_out_o, pin, seen, usr;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    logic [15:0] ev;
    int          bad_count, checked, seed, l, c, s;
    cior_top i_dut (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .acq_trig_wait_i(st[0]),
        .acq_active_i(st[1]), .frame_trig_wait_i(st[2]), .frame_active_i(st[3]),
        .exposure_active_i(st[4]), .transfer_wait_i(st[5]), .counter_active_i(st[6]),
        .timer_active_i(st[7]), .sw_trig_i(ev[0]), .timer_start_i(ev[5]),
        .timer_end_i(ev[6]), .counter_start_i(ev[8]), .counter_end_i(ev[9]),
        .action_i(ev[15:14]), .line_in_i, .line_out_o, .trig_o);
    cior_equip i_eq (.level_i(pin), .line_out_i(line_out_o), .line_in_o(line_in_i),
        .seen_o(seen));
    always #25 clk_i = ~clk_i;
    // ==========================================
    // Reference model and bus tasks
    function automatic logic mdl_out(int k);
        if (k == 0)
            return 1'b0;
        return (k < 9) ? st[k-1] : usr[k-9];
    endfunction
    function automatic logic mdl_trig(int k);
        case (k)
            0: return ev[0];
            1, 2, 3, 4: return pin[k-1];
            7: return st[7];
            10, 11, 12, 13: return usr[k-10];
            default: return ev[k];
        endcase
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && n < 20)
        begin
            @(posedge clk_i);
            n++;
        end
        if (n == 20)
            bad_count++;
        // Values as sampled at this edge; the slave updates them by NBA
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic summarize();
        if (bad_count == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ==========================================
    // Scenarios
    initial
    begin
        #500us;
        bad_count++;
        summarize();
    end
    initial
    begin
        {clk_i, wb_cyc_i, wb_stb_i, wb_we_i, ce_i, rst_i} = 6'h3;
        {wb_adr_i, wb_sel_i, wb_dat_i, st, ev, pin} = 0;
        wb_sel_i = 4'hf;
        seed = 47;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (l = 0; l < 8; l++)
        begin
            wb(1'b1, 8'h00, l, q);
            wb(1'b0, 8'h04, 0, q);
            chk(q, (((l < 2 || l == 6) ? 1 : (l == 7) ? 2 : 3) << 12)
                | ((l < 4) ? 32'h100 : 32'h0));
        end
        wb(1'b1, 8'h20, 32'hffffffff, q);
        wb(1'b0, 8'h20, 0, q);
        chk(q, 0);
        wb(1'b1, 8'h10, 3, q);
        wb(1'b0, 8'h14, 0, q);
        chk(q, 0);
        for (l = 0; l < 4; l++)
            for (c = 0; c < 14; c++)
            begin
                wb(1'b1, 8'h00, l, q);
                st <= 8'($random(seed));
                usr = 4'($random(seed));
                wb(1'b1, 8'h0c, {28'h0, usr}, q);
                i = 1'($random(seed));
                wb(1'b1, 8'h04, {27'h0, i, c[3:0]}, q);
                s = (c < 13) ? c : s;
                repeat (3) @(posedge clk_i);
                chk(seen[l], mdl_out(s) ^ i);
                wb(1'b0, 8'h08, 0, q);
                chk(q[l], mdl_out(s) ^ i);
            end
        wb(1'b1, 8'h00, 4, q);
        wb(1'b1, 8'h04, 5, q);
        wb(1'b1, 8'h04, 4, q);
        wb(1'b0, 8'h04, 0, q);
        chk(q[4:0], 5);
        for (c = 0; c < 16; c++)
        begin
            wb(1'b1, 8'h10, c % 8, q);
            wb(1'b1, 8'h14, c, q);
            ev <= 16'($random(seed));
            pin <= 4'($random(seed));
            st <= 8'($random(seed));
            repeat (6) @(posedge clk_i);
            chk(trig_o[c % 8], mdl_trig(c));
            wb(1'b0, 8'h08, 0, q);
            chk(q[7:4], pin);
        end
        // Enable low: sources move, outputs must not
        q = {20'h0, seen, trig_o};
        ce_i <= 1'b0;
        ev <= ~ev;
        pin <= ~pin;
        st <= ~st;
        repeat (6) @(posedge clk_i);
        chk({20'h0, seen, trig_o}, q);
        ce_i <= 1'b1;
        @(posedge clk_i);
        summarize();
    end
endmodule
`default_nettype wire
